/* File: src/ptma_regs.vh */
// Purpose: Register map, field positions and codes of the macrocell array
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef PTMA_REGS_VH
`define PTMA_REGS_VH

// Register offsets
`define PTMA_CTRL_OFS 12'h000
`define PTMA_STAT_OFS 12'h004
`define PTMA_CELL_BASE 12'h040
`define PTMA_CELL_LAST 12'h07C
`define PTMA_TERM_BASE 12'h100
`define PTMA_TERM_LAST 12'h2FC

// Block control fields
`define PTMA_CTRL_BLOCK_ASYNC_CLEAR_ONE_INV 0
`define PTMA_CTRL_BLOCK_ASYNC_CLEAR_TWO_INV 1
`define PTMA_CTRL_BLOCK_CLOCK_ONE_FALL 2
`define PTMA_CTRL_CLK2_FALL 3
`define PTMA_CTRL_RST 4'h0

// Macrocell configuration fields
`define PTMA_CFG_BYPASS 0
`define PTMA_CFG_TYPE_LO 1
`define PTMA_CFG_CLKSEL 3
`define PTMA_CFG_CLR_LO 4
`define PTMA_CFG_LEND0 6
`define PTMA_CFG_LEND1 7
`define PTMA_CFG_INV1 8
`define PTMA_CFG_PRESET 9
`define PTMA_CFG_CHAIN 10
`define PTMA_CFG_XOR 11
`define PTMA_CFG_RST 12'h001

// Register types and clear choices
`define PTMA_FF_D 2'h0
`define PTMA_FF_T 2'h1
`define PTMA_FF_JK 2'h2
`define PTMA_FF_SR 2'h3
`define PTMA_CLR_NONE 2'h0
`define PTMA_CLR_ONE 2'h1
`define PTMA_CLR_TWO 2'h2

`endif

/* File: src/ptma_macrocell_array.v */
// Purpose: Product-term macrocell array with APB configuration
// Assumes: Block clocks, enables, clears and chip reset arrive from pins
// Notes: Block clock edges are detected on clk_sys after a three-stage filter
//
// Operation
// - Sixteen macrocells, two terms and register each
// - Thirty-two shared inputs feed all product terms
// - Nine macrocell outputs fed back into array
// - Per macrocell register or combinatorial bypass
// - Register acts as D, T, JK, SR
// - Terms go to OR/XOR or neighbour
// - Second product term optionally inverted
// - Register clocked by one of two clocks
// - Clocks and enables come from outside
// - Selected clock always gated by paired enable
// - Each block clock has its own edge polarity
// - Two clears derived, applied to registers
// - Register uses clear one, two, or none
// - Either clear optionally inverted inside block
// - OR takes own two plus thirty borrowed
// - Up to fifteen chained sets of two
// - Preset by inverting around the register
// - Chip reset clears every register, overrides all
`timescale 1ns/1ps
`default_nettype none
`include "ptma_regs.vh"

module ptma_macrocell_array (
  // System
  input wire clk_sys,
  input wire rst,
  // APB slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Local routing data inputs
  input wire [31:0] dataIn,
  // Block control inputs
  input wire blockClockOne,
  input wire blockClockTwo,
  input wire blockClockOneEnable,
  input wire blockClockTwoEnable,
  input wire blockAsyncClearOne,
  input wire blockAsyncClearTwo,
  input wire chipWideResetN,
  // Macrocell outputs
  output reg [15:0] cellOut
);

  localparam CELLS = 16;
  localparam TERMS = 32;
  localparam LITS = 41;
  localparam SYNCS = 7;

  // Product term: every selected true literal high, every selected complement low
  function pterm;
    input [LITS-1:0] trueMask;
    input [LITS-1:0] compMask;
    input [LITS-1:0] lits;
    begin
      pterm = (&(~trueMask | lits)) & (&(~compMask | ~lits));
    end
  endfunction

  // Next value of one register in its true sense
  function nextReg;
    input [1:0] ffType;
    input q;
    input a;
    input b;
    begin
      case (ffType)
        `PTMA_FF_D: nextReg = a;
        `PTMA_FF_T: nextReg = q ^ a;
        `PTMA_FF_JK: nextReg = (a & ~q) | (~b & q);
        `PTMA_FF_SR: nextReg = a | (q & ~b);
        default: nextReg = q;
      endcase
    end
  endfunction

  // Configuration storage
  reg [3:0] ctrl;
  reg [11:0] cellCfg [0:CELLS-1];
  reg [LITS-1:0] termTrue [0:TERMS-1];
  reg [LITS-1:0] termComp [0:TERMS-1];

  // Pin synchronisers: block_clock_one, clk2, en1, en2, block_async_clear_one, block_async_clear_two, chip reset
  reg [SYNCS-1:0] syncA;
  reg [SYNCS-1:0] syncB;
  reg [SYNCS-1:0] syncC;
  reg [SYNCS-1:0] pinLevel;
  wire [SYNCS-1:0] pinIn;
  wire [SYNCS-1:0] agree;
  wire [SYNCS-1:0] next_pinLevel;

  assign pinIn = {chipWideResetN, blockAsyncClearTwo, blockAsyncClearOne,
    blockClockTwoEnable, blockClockOneEnable, blockClockTwo, blockClockOne};
  assign agree = ~(syncB ^ syncC);
  assign next_pinLevel = (agree & syncC) | (~agree & pinLevel);

  always @(posedge clk_sys) begin
    if (rst) begin
      syncA <= 7'h40;
      syncB <= 7'h40;
      syncC <= 7'h40;
      pinLevel <= 7'h40;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
      pinLevel <= next_pinLevel;
    end
  end

  // Clock events, enables and clears
  wire clkOneEvent;
  wire clkTwoEvent;
  wire tickOne;
  wire tickTwo;
  wire clearOne;
  wire clearTwo;
  wire chipReset;

  assign clkOneEvent = (next_pinLevel[0] != pinLevel[0]) &
    (next_pinLevel[0] ^ ctrl[`PTMA_CTRL_BLOCK_CLOCK_ONE_FALL]);
  assign clkTwoEvent = (next_pinLevel[1] != pinLevel[1]) &
    (next_pinLevel[1] ^ ctrl[`PTMA_CTRL_CLK2_FALL]);
  assign tickOne = clkOneEvent & pinLevel[2];
  assign tickTwo = clkTwoEvent & pinLevel[3];
  assign clearOne = pinLevel[4] ^ ctrl[`PTMA_CTRL_BLOCK_ASYNC_CLEAR_ONE_INV];
  assign clearTwo = pinLevel[5] ^ ctrl[`PTMA_CTRL_BLOCK_ASYNC_CLEAR_TWO_INV];
  assign chipReset = ~pinLevel[6];

  // Macrocell logic
  reg [CELLS-1:0] stored;
  reg [CELLS-1:0] next_stored;
  reg [CELLS-1:0] combVal;
  reg [CELLS-1:0] expChain;
  wire [LITS-1:0] lits;

  assign lits = {cellOut[8:0], dataIn};

  integer m;
  reg [11:0] cfg;
  reg tOne;
  reg tTwo;
  reg primOne;
  reg primTwo;
  reg expIn;
  reg sumA;
  reg logicVal;
  reg qTrue;
  reg nextTrue;

  always @* begin
    next_stored = stored;
    combVal = 16'h0000;
    expChain = 16'h0000;
    cfg = 12'h000;
    tOne = 1'b0;
    tTwo = 1'b0;
    primOne = 1'b0;
    primTwo = 1'b0;
    expIn = 1'b0;
    sumA = 1'b0;
    logicVal = 1'b0;
    qTrue = 1'b0;
    nextTrue = 1'b0;
    for (m = 0; m < CELLS; m = m + 1) begin
      cfg = cellCfg[m];
      tOne = pterm(termTrue[2*m], termComp[2*m], lits);
      tTwo = pterm(termTrue[2*m+1], termComp[2*m+1], lits) ^ cfg[`PTMA_CFG_INV1];
      primOne = tOne & ~cfg[`PTMA_CFG_LEND0];
      primTwo = tTwo & ~cfg[`PTMA_CFG_LEND1];
      expIn = 1'b0;
      if (m > 0) begin
        expIn = expChain[m-1] & cfg[`PTMA_CFG_CHAIN];
      end
      expChain[m] = (tOne & cfg[`PTMA_CFG_LEND0]) | (tTwo & cfg[`PTMA_CFG_LEND1]) | expIn;
      if (cfg[`PTMA_CFG_TYPE_LO+1]) begin
        sumA = primOne | expIn;
      end else begin
        sumA = primOne | primTwo | expIn;
      end
      logicVal = sumA ^ cfg[`PTMA_CFG_XOR];
      qTrue = stored[m] ^ cfg[`PTMA_CFG_PRESET];
      nextTrue = nextReg(cfg[`PTMA_CFG_TYPE_LO+1:`PTMA_CFG_TYPE_LO], qTrue, logicVal, primTwo);
      next_stored[m] = nextTrue ^ cfg[`PTMA_CFG_PRESET];
      if (cfg[`PTMA_CFG_BYPASS]) begin
        combVal[m] = logicVal;
      end else begin
        combVal[m] = qTrue;
      end
    end
  end

  // Macrocell registers
  integer r;
  reg [1:0] clrSel;
  reg [CELLS-1:0] cellTick;
  reg [CELLS-1:0] cellClear;

  // Per-cell clear choice and clock choice
  always @* begin
    clrSel = 2'h0;
    cellTick = 16'h0000;
    cellClear = 16'h0000;
    for (r = 0; r < CELLS; r = r + 1) begin
      clrSel = cellCfg[r][`PTMA_CFG_CLR_LO+1:`PTMA_CFG_CLR_LO];
      cellClear[r] = ((clrSel == `PTMA_CLR_ONE) & clearOne) | ((clrSel == `PTMA_CLR_TWO) & clearTwo);
      if (cellCfg[r][`PTMA_CFG_CLKSEL]) begin
        cellTick[r] = tickTwo;
      end else begin
        cellTick[r] = tickOne;
      end
    end
  end

  // Chip reset beats the clears, a clear beats the clock
  // Without a clock event, clear or chip reset every register keeps its value
  always @(posedge clk_sys) begin
    if (rst | chipReset) begin
      stored <= 16'h0000;
    end else begin
      stored <= ~cellClear & ((cellTick & next_stored) | (~cellTick & stored));
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      cellOut <= 16'h0000;
    end else begin
      cellOut <= combVal;
    end
  end

  // APB decode
  wire isCtrl;
  wire isStat;
  wire isCell;
  wire isTerm;
  wire [11:0] cellOfs;
  wire [11:0] termOfs;
  wire [3:0] cellIdx;
  wire [4:0] termIdx;
  wire [1:0] termWord;
  wire apbDone;

  assign isCtrl = (paddr == `PTMA_CTRL_OFS);
  assign isStat = (paddr == `PTMA_STAT_OFS);
  assign isCell = (paddr >= `PTMA_CELL_BASE) && (paddr <= `PTMA_CELL_LAST) && (paddr[1:0] == 2'h0);
  assign isTerm = (paddr >= `PTMA_TERM_BASE) && (paddr <= `PTMA_TERM_LAST) && (paddr[1:0] == 2'h0);
  assign cellOfs = paddr - `PTMA_CELL_BASE;
  assign termOfs = paddr - `PTMA_TERM_BASE;
  assign cellIdx = cellOfs[5:2];
  assign termIdx = termOfs[8:4];
  assign termWord = termOfs[3:2];
  assign apbDone = psel & penable & pready;

  reg [31:0] next_prdata;
  reg next_pslverr;

  always @* begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (isCtrl) begin
      next_prdata = {28'h000_0000, ctrl};
    end else if (isStat) begin
      next_prdata = {9'h000, pinLevel, cellOut};
    end else if (isCell) begin
      next_prdata = {20'h0_0000, cellCfg[cellIdx]};
    end else if (isTerm) begin
      case (termWord)
        2'h0: next_prdata = termTrue[termIdx][31:0];
        2'h1: next_prdata = {23'h00_0000, termTrue[termIdx][40:32]};
        2'h2: next_prdata = termComp[termIdx][31:0];
        default: next_prdata = {23'h00_0000, termComp[termIdx][40:32]};
      endcase
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // APB answer one cycle into the access phase
  always @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr | (pwrite & isStat);
    end else begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Configuration writes
  integer i;

  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl <= `PTMA_CTRL_RST;
      for (i = 0; i < CELLS; i = i + 1) begin
        cellCfg[i] <= `PTMA_CFG_RST;
      end
      for (i = 0; i < TERMS; i = i + 1) begin
        termTrue[i] <= 41'h000_0000_0000;
        termComp[i] <= 41'h000_0000_0000;
      end
    end else if (apbDone & pwrite) begin
      if (isCtrl) begin
        ctrl <= pwdata[3:0];
      end
      if (isCell) begin
        cellCfg[cellIdx] <= pwdata[11:0];
      end
      if (isTerm) begin
        case (termWord)
          2'h0: termTrue[termIdx][31:0] <= pwdata;
          2'h1: termTrue[termIdx][40:32] <= pwdata[8:0];
          2'h2: termComp[termIdx][31:0] <= pwdata;
          default: termComp[termIdx][40:32] <= pwdata[8:0];
        endcase
      end
    end
  end

endmodule // ptma_macrocell_array

`default_nettype wire

/* File: dv/ptma_macrocell_array_assertions.sv */
// Purpose: Port checks of the macrocell array
// Assumes: Two-cycle access phase, registered outputs
// Notes: Bound to the design top
`timescale 1ns/1ps
`default_nettype none
module ptma_macrocell_array_assertions (
  // System
  input wire logic clk_sys,
  input wire logic rst,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Cells
  input wire logic [15:0] cellOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ready_after_access: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_setup_no_ready: assert property (psel && !penable |=> !pready)
    else $error("ready early");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("stray error");
  a_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0000_0000)
    else $error("read data not idle");
  a_status_refused: assert property (pready && pwrite && paddr == 12'h004 |-> pslverr)
    else $error("status write taken");
  a_cell_cfg_ok: assert property (pready && paddr[11:6] == 6'h01 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("cell config refused");
  a_reset_quiet: assert property ($fell(rst) |-> !pready && cellOut == 16'h0000)
    else $error("outputs not cleared");
endmodule // ptma_macrocell_array_assertions
bind ptma_macrocell_array ptma_macrocell_array_assertions i_chk (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .cellOut(cellOut));
`default_nettype wire

/* File: dv/ptma_routing_model.sv */
// Purpose: Local routing feeding the macrocell array
// Assumes: Bench requests on clk_sys
// Notes: A kick raises block clocks for nine cycles
`timescale 1ns/1ps
`default_nettype none
module ptma_routing_model (
  // System
  input wire logic clk_sys,
  // Requests
  input wire logic [1:0] kick,
  input wire logic [4:0] ctl,
  input wire logic [31:0] dReq,
  // Block side
  output var logic [31:0] dataIn = 32'h0000_0000,
  output var logic [1:0] clkOut = 2'h0,
  output var logic [4:0] ctlOut = 5'h11
);
  logic [3:0] hold = 4'h0;
  always @(posedge clk_sys) begin
    dataIn <= dReq;
    ctlOut <= ctl;
    if (kick != 2'h0) begin
      clkOut <= kick;
      hold <= 4'h8;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else begin
      clkOut <= 2'h0;
    end
  end
endmodule // ptma_routing_model
`default_nettype wire

/* File: dv/ptma_macrocell_array_tb.sv */
// Purpose: Self-checking bench of the macrocell array
// Assumes: Two-cycle APB access, short pin filter
// Notes: Routing model drives data and block controls
`timescale 1ns/1ps
`default_nettype none
module ptma_macrocell_array_tb;
  typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic e;} ptma_row_t;
  localparam logic W = 1'b1, R = 1'b0, OK = 1'b0, BAD = 1'b1;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, dReq = 32'h0000_0000, prdata, dataIn, r;
  logic [15:0] cellOut;
  logic [1:0] clkBlk, kick = 2'h0;
  logic [4:0] ctl = 5'h11, ctlPin;
  int numErrors = 0, numChecks = 0, tick = 0;
  ptma_row_t rows [$] = '{'{12'h000,R,32'h0000_0000,OK}, '{12'h07C,R,32'h0000_0001,OK},
    '{12'h080,R,32'h0000_0000,BAD}, '{12'h008,R,32'h0000_0000,BAD}, '{12'h004,W,32'h0000_FFFF,BAD},
    '{12'h000,W,32'h0000_000C,OK}, '{12'h000,R,32'h0000_000C,OK}, '{12'h100,W,32'h0000_0001,OK},
    '{12'h120,W,32'h0000_0008,OK}, '{12'h130,W,32'h0000_0004,OK}, '{12'h140,W,32'h0000_0010,OK},
    '{12'h150,W,32'h0000_0010,OK}, '{12'h180,W,32'h0000_0020,OK}, '{12'h1A0,W,32'h0000_0040,OK},
    '{12'h1C0,W,32'h0000_0080,OK}, '{12'h1D0,W,32'h0000_0100,OK}, '{12'h1E0,W,32'h0000_0080,OK},
    '{12'h1F0,W,32'h0000_0100,OK}, '{12'h204,W,32'h0000_0001,OK}, '{12'h040,W,32'h0000_0081,OK},
    '{12'h044,W,32'h0000_0141,OK}, '{12'h048,W,32'h0000_0401,OK}, '{12'h050,W,32'h0000_0080,OK},
    '{12'h054,W,32'h0000_0082,OK}, '{12'h058,W,32'h0000_0004,OK}, '{12'h05C,W,32'h0000_0006,OK},
    '{12'h060,W,32'h0000_0081,OK}, '{12'h044,R,32'h0000_0141,OK}};
  logic [31:0] vd [3] = '{32'h0000_0019, 32'h0000_0004, 32'h0000_0008};
  logic [3:0] vx [3] = '{4'hF, 4'h0, 4'h6};
  logic [4:0] sc [6] = '{5'h11, 5'h11, 5'h11, 5'h10, 5'h12, 5'h12};
  logic [1:0] sk [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2};
  logic [11:0] sd [6] = '{12'h060, 12'h080, 12'h140, 12'h020, 12'h020, 12'h020};
  logic [3:0] sx [6] = '{4'h3, 4'hE, 4'h0, 4'h0, 4'h0, 4'h1};
  always #5 clk_sys = ~clk_sys;
  ptma_routing_model i_ptma_routing_model (.clk_sys(clk_sys), .kick(kick), .ctl(ctl), .dReq(dReq),
    .dataIn(dataIn), .clkOut(clkBlk), .ctlOut(ctlPin));
  ptma_macrocell_array i_ptma_macrocell_array (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .dataIn(dataIn), .blockClockOne(clkBlk[0]), .blockClockTwo(clkBlk[1]), .blockClockOneEnable(ctlPin[0]),
    .blockClockTwoEnable(ctlPin[1]), .blockAsyncClearOne(ctlPin[2]), .blockAsyncClearTwo(ctlPin[3]),
    .chipWideResetN(ctlPin[4]), .cellOut(cellOut));
  task close_out;
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    numChecks++;
    if (s !== x) begin
      numErrors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    cyc(1);
    penable <= 1'b1;
    do cyc(1); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(1);
  endtask
  always @(posedge clk_sys) begin
    tick++;
    if (tick == 5000) begin
      numErrors++;
      close_out;
    end
  end
  initial begin
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk({31'h0, e}, {31'h0, rows[i].e});
      if (!rows[i].w) chk(r, rows[i].d);
    end
    $display("test registers end");
    for (int i = 0; i < 3; i++) begin
      dReq <= vd[i];
      cyc(10);
      chk({28'h0, cellOut[8], cellOut[2:0]}, {28'h0, vx[i]});
    end
    $display("test logic end");
    ctl <= 5'h01;
    cyc(8);
    ctl <= 5'h11;
    cyc(8);
    chk({28'h0, cellOut[7:4]}, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      if (i == 5) apb(12'h050, W, 32'h0000_0088);
      ctl <= sc[i];
      dReq <= {20'h0, sd[i]};
      cyc(8);
      kick <= sk[i];
      cyc(1);
      kick <= 2'h0;
      cyc(24);
      chk({28'h0, cellOut[7:4]}, {28'h0, sx[i]});
    end
    $display("test registers modes end");
    apb(12'h050, W, 32'h0000_0098);
    ctl <= 5'h16;
    cyc(10);
    chk({31'h0, cellOut[4]}, 32'h0000_0000);
    ctl <= 5'h12;
    apb(12'h000, W, 32'h0000_000D);
    apb(12'h050, W, 32'h0000_0298);
    cyc(10);
    chk({31'h0, cellOut[4]}, 32'h0000_0001);
    dReq <= 32'h0000_0000;
    cyc(8);
    kick <= 2'h2;
    cyc(1);
    kick <= 2'h0;
    cyc(24);
    chk({31'h0, cellOut[4]}, 32'h0000_0001);
    ctl <= 5'h16;
    apb(12'h000, W, 32'h0000_0005);
    cyc(4);
    kick <= 2'h2;
    cyc(1);
    kick <= 2'h0;
    cyc(7);
    chk({31'h0, cellOut[4]}, 32'h0000_0000);
    cyc(17);
    ctl <= 5'h06;
    cyc(10);
    chk({31'h0, cellOut[4]}, 32'h0000_0001);
    ctl <= 5'h16;
    cyc(8);
    $display("test clears end");
    close_out;
  end
endmodule // ptma_macrocell_array_tb
`default_nettype wire
